// *** rtl/ppcc_defs.svh ***
`ifndef PPCC_DEFS_SVH
`define PPCC_DEFS_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define PPCC_CFG_ADDR      8'hF7   // pwm_cycle_config
`define PPCC_CMP_BASE      8'hE8   // chan_compare_low of channel 0
`define PPCC_CMP_STRIDE    8'h02   // low/high pair per channel
`define PPCC_NCH           3       // number of compare channels

// ----------------------------------------------------------------------
// pwm_cycle_config field positions and reset value
// ----------------------------------------------------------------------
`define PPCC_BIT_RELOAD_REG_SELECT     7       // reload_reg_select
`define PPCC_BIT_CYCLE_OVF_INT_EN      6       // cycle_ovf_int_en
`define PPCC_BIT_CYCLE_OVF_FLAG      5       // cycle_ovf_flag
`define PPCC_BIT_UNUSED    4       // always reads zero
`define PPCC_BIT_WIDE_PWM_RELOAD_EN     3       // wide_pwm_reload_en
`define PPCC_CYCLE_LEN_SEL_LSB     0       // cycle_len_sel[2:0]
`define PPCC_CFG_RESET     8'h00

// ----------------------------------------------------------------------
// cycle lengths
// ----------------------------------------------------------------------
`define PPCC_MIN_LEN       5'h08   // length for code 000
`define PPCC_WIDE_LEN      5'h10   // length of a 16-bit pwm channel

`endif

// *** rtl/ppcc_pkg.sv ***
package ppcc_pkg;
    `include "ppcc_defs.svh"

    // per-channel mode as seen by this block
    typedef enum logic [1:0] {
        PPCC_MODE_OTHER,
        PPCC_MODE_NBIT,
        PPCC_MODE_WIDE
    } ppcc_mode_t;

    // special-function register access, one cycle strobes
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ppcc_sfr_req_t;

    // pwm_cycle_config contents
    typedef struct packed {
        logic       reload_reg_select;
        logic       cycle_ovf_int_en;
        logic       cycle_ovf_flag;
        logic       wide_pwm_reload_en;
        logic [2:0] cycle_len_sel;
    } ppcc_cfg_t;

    // decoded compare-register address
    typedef struct packed {
        logic       hit;
        logic [1:0] chan;
        logic       hi;
    } ppcc_dec_t;

    // whole state of the top module
    typedef struct packed {
        ppcc_cfg_t                        cfg;
        logic [`PPCC_NCH-1:0][15:0]       cmp;
        logic [`PPCC_NCH-1:0][4:0]        chan_len;
        logic [15:0]                      prev_cnt;
        logic                             rd_pend;
        logic                             rd_mem;
        logic [7:0]                       rd_early;
        logic [7:0]                       rdata;
        logic                             rvalid;
        logic                             irq;
    } ppcc_state_t;
endpackage

// *** rtl/ppcc_reload_mem.sv ***
`timescale 1ns/1ps
// shadow reload registers, one 16-bit word per channel
module ppcc_reload_mem #(
    parameter int NCH = 3
) (
    input  wire logic                  i_ref_clk,  // system clock
    input  wire logic                  i_rst_n,    // async reset, active low
    input  wire logic                  i_wr,       // byte write strobe
    input  wire logic                  i_rd,       // byte read strobe
    input  wire logic [1:0]            i_chan,     // channel index
    input  wire logic                  i_hi,       // high byte select
    input  wire logic [7:0]            i_wdata,    // write byte
    output logic      [7:0]            o_rdata,    // read byte, one cycle later
    output logic      [NCH-1:0][15:0]  o_words     // all words for reload copy
);
    typedef struct packed {
        logic [NCH-1:0][15:0] words;
        logic [7:0]           rdata;
    } ppcc_mem_state_t;

    ppcc_mem_state_t st_q;
    ppcc_mem_state_t st_d;

    // ------------------------------------------------------------------
    // byte access
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        if (i_wr) begin
            if (i_hi) begin
                st_d.words[i_chan][15:8] = i_wdata;
            end else begin
                st_d.words[i_chan][7:0] = i_wdata;
            end
        end
        // read data is registered; returns the contents before a same-cycle write
        if (i_rd) begin
            st_d.rdata = i_hi ? st_q.words[i_chan][15:8] : st_q.words[i_chan][7:0];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_rdata = st_q.rdata;
    assign o_words = st_q.words;
endmodule

// *** rtl/ppcc_top.sv ***
`timescale 1ns/1ps
`include "ppcc_defs.svh"
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
module ppcc_top
    import ppcc_pkg::*;
(
    input  wire logic                           i_ref_clk,        // system clock, 200 MHz
    input  wire logic                           i_rst_n,          // async reset, active low
    input  wire ppcc_pkg::ppcc_sfr_req_t        i_sfr,            // register access strobes
    input  wire logic [15:0]                    i_cnt,            // main_array_counter value
    input  wire logic                           i_cnt_ovf,        // counter wrapped, one pulse
    input  wire ppcc_pkg::ppcc_mode_t [`PPCC_NCH-1:0] i_chan_mode, // per-channel mode
    output logic [7:0]                          o_sfr_rdata,      // read data
    output logic                                o_sfr_rvalid,     // read data valid pulse
    output logic [`PPCC_NCH-1:0][15:0]          o_cmp,            // chan_compare_regs values
    output logic [`PPCC_NCH-1:0][4:0]           o_chan_len,       // effective cycle length
    output logic [2:0]                          o_cycle_len_sel,  // cycle_len_sel field
    output logic                                o_cycle_ovf_flag, // cycle_ovf_flag
    output logic                                o_pca_int         // counter-array interrupt
);
    import ppcc_pkg::*;

    ppcc_state_t st_q;
    ppcc_state_t st_d;

    // ------------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------------

    // compare address decode, shared by the read and write paths
    function automatic ppcc_dec_t cmp_decode(input logic [7:0] addr);
        ppcc_dec_t d;
        logic [7:0] off;
        d   = '0;
        off = addr - `PPCC_CMP_BASE;
        if (addr >= `PPCC_CMP_BASE && off < 8'(`PPCC_NCH * 2)) begin
            d.hit  = 1'b1;
            d.chan = off[2:1];
            d.hi   = off[0];
        end
        return d;
    endfunction

    // mask of the counter bits that make up one pwm cycle
    function automatic logic [15:0] len_mask(input logic [2:0] sel);
        logic [4:0] len;
        len = `PPCC_MIN_LEN + {2'b00, sel};
        return 16'((17'h1_0000 >> (5'd16 - len)) - 17'h1);
    endfunction

    ppcc_dec_t                     dec;
    logic                          mem_wr;
    logic                          mem_rd;
    logic [7:0]                    mem_rdata;
    logic [`PPCC_NCH-1:0][15:0]    reload;
    logic [15:0]                   mask;
    logic                          cyc_evt;
    logic                          cfg_hit;

    // ------------------------------------------------------------------
    // address steering
    // ------------------------------------------------------------------

    // shadow registers answer only while the select bit is set
    always_comb begin
        dec     = cmp_decode(i_sfr.addr);
        cfg_hit = (i_sfr.addr == `PPCC_CFG_ADDR);
        mem_wr  = i_sfr.wr && dec.hit && st_q.cfg.reload_reg_select;
        mem_rd  = i_sfr.rd && dec.hit && st_q.cfg.reload_reg_select;
    end

    ppcc_reload_mem #(
        .NCH (`PPCC_NCH)
    ) u_reload (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_wr      (mem_wr),
        .i_rd      (mem_rd),
        .i_chan    (dec.chan),
        .i_hi      (dec.hi),
        .i_wdata   (i_sfr.wdata),
        .o_rdata   (mem_rdata),
        .o_words   (reload)
    );

    // ------------------------------------------------------------------
    // cycle overflow detection
    // ------------------------------------------------------------------

    // the low bits were all ones and the counter moved on: the selected bit carried
    always_comb begin
        mask    = len_mask(st_q.cfg.cycle_len_sel);
        cyc_evt = ((st_q.prev_cnt & mask) == mask) && (i_cnt != st_q.prev_cnt);
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d          = st_q;
        st_d.prev_cnt = i_cnt;
        st_d.rvalid   = 1'b0;

        // configuration write; bit 4 has no storage so it is dropped
        if (i_sfr.wr && cfg_hit) begin
            st_d.cfg.reload_reg_select  = i_sfr.wdata[`PPCC_BIT_RELOAD_REG_SELECT];
            st_d.cfg.cycle_ovf_int_en   = i_sfr.wdata[`PPCC_BIT_CYCLE_OVF_INT_EN];
            st_d.cfg.cycle_ovf_flag     = i_sfr.wdata[`PPCC_BIT_CYCLE_OVF_FLAG];
            st_d.cfg.wide_pwm_reload_en = i_sfr.wdata[`PPCC_BIT_WIDE_PWM_RELOAD_EN];
            st_d.cfg.cycle_len_sel      = i_sfr.wdata[`PPCC_CYCLE_LEN_SEL_LSB +: 3];
        end

        // hardware set comes after the write so an event is never lost
        if (cyc_evt) begin
            st_d.cfg.cycle_ovf_flag = 1'b1;
        end

        // ordinary compare write when the select bit is clear
        if (i_sfr.wr && dec.hit && !st_q.cfg.reload_reg_select) begin
            if (dec.hi) begin
                st_d.cmp[dec.chan][15:8] = i_sfr.wdata;
            end else begin
                st_d.cmp[dec.chan][7:0] = i_sfr.wdata;
            end
        end

        // reload copy per channel; a hardware reload overrides a same-cycle write
        for (int i = 0; i < `PPCC_NCH; i++) begin
            unique case (i_chan_mode[i])
                PPCC_MODE_WIDE: begin
                    st_d.chan_len[i] = `PPCC_WIDE_LEN;
                    if (i_cnt_ovf && st_q.cfg.wide_pwm_reload_en) begin
                        st_d.cmp[i] = reload[i];
                    end
                end
                PPCC_MODE_NBIT: begin
                    st_d.chan_len[i] = `PPCC_MIN_LEN + {2'b00, st_q.cfg.cycle_len_sel};
                    // 8-bit cycles have no reload; the shadow word only serves 9..15
                    if (cyc_evt && st_q.cfg.cycle_len_sel != 3'h0) begin
                        st_d.cmp[i] = reload[i];
                    end
                end
                default: begin
                    // other modes: shadow contents never reach the compare register
                    st_d.chan_len[i] = `PPCC_MIN_LEN + {2'b00, st_q.cfg.cycle_len_sel};
                end
            endcase
        end

        // read, stage one: pick the source, memory answers a cycle later
        st_d.rd_pend  = i_sfr.rd;
        st_d.rd_mem   = mem_rd;
        st_d.rd_early = 8'h00;
        if (i_sfr.rd && cfg_hit) begin
            st_d.rd_early = {st_q.cfg.reload_reg_select,
                             st_q.cfg.cycle_ovf_int_en,
                             st_q.cfg.cycle_ovf_flag,
                             1'b0,
                             st_q.cfg.wide_pwm_reload_en,
                             st_q.cfg.cycle_len_sel};
        end else if (i_sfr.rd && dec.hit && !st_q.cfg.reload_reg_select) begin
            st_d.rd_early = dec.hi ? st_q.cmp[dec.chan][15:8]
                                   : st_q.cmp[dec.chan][7:0];
        end

        // read, stage two: present the byte with a valid pulse
        if (st_q.rd_pend) begin
            st_d.rdata  = st_q.rd_mem ? mem_rdata : st_q.rd_early;
            st_d.rvalid = 1'b1;
        end

        // interrupt follows the masked flag one cycle later
        st_d.irq = st_q.cfg.cycle_ovf_flag && st_q.cfg.cycle_ovf_int_en;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q     <= '0;
            st_q.cfg <= ppcc_cfg_t'(`PPCC_CFG_RESET);
            for (int i = 0; i < `PPCC_NCH; i++) begin
                st_q.chan_len[i] <= `PPCC_MIN_LEN;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign o_sfr_rdata      = st_q.rdata;
    assign o_sfr_rvalid     = st_q.rvalid;
    assign o_cmp            = st_q.cmp;
    assign o_chan_len       = st_q.chan_len;
    assign o_cycle_len_sel  = st_q.cfg.cycle_len_sel;
    assign o_cycle_ovf_flag = st_q.cfg.cycle_ovf_flag;
    assign o_pca_int        = st_q.irq;
endmodule

// *** testbench/ppcc_top_sva.sv ***
`timescale 1ns/1ps
`include "ppcc_defs.svh"
// --------------------
// port checks
// --------------------
module ppcc_top_sva
    import ppcc_pkg::*;
(
    input wire logic                           i_ref_clk,        // clock
    input wire logic                           i_rst_n,          // reset, active low
    input wire ppcc_pkg::ppcc_sfr_req_t        i_sfr,            // register access
    input wire logic [15:0]                    i_cnt,            // counter
    input wire logic                           i_cnt_ovf,        // counter wrap
    input wire ppcc_pkg::ppcc_mode_t [`PPCC_NCH-1:0] i_chan_mode, // modes
    input wire logic [7:0]                     o_sfr_rdata,      // read data
    input wire logic                           o_sfr_rvalid,     // read valid
    input wire logic [`PPCC_NCH-1:0][15:0]     o_cmp,            // compares
    input wire logic [`PPCC_NCH-1:0][4:0]      o_chan_len,       // lengths
    input wire logic [2:0]                     o_cycle_len_sel,  // length field
    input wire logic                           o_cycle_ovf_flag, // flag
    input wire logic                           o_pca_int         // interrupt
);
    logic        rd_cfg;
    logic        rd_none;
    logic        wr_clr;
    logic [15:0] len_mask;
    // decoded accesses; the mask holds the low 8+sel counter bits
    assign rd_cfg   = i_sfr.rd && (i_sfr.addr == `PPCC_CFG_ADDR);
    assign rd_none  = i_sfr.rd && (i_sfr.addr == 8'h00);
    assign wr_clr   = i_sfr.wr && (i_sfr.addr == `PPCC_CFG_ADDR) && !i_sfr.wdata[5];
    assign len_mask = 16'hFFFF >> (4'h8 - {1'b0, o_cycle_len_sel});
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_read_answer_two: assert property (i_sfr.rd |-> ##2 o_sfr_rvalid)
        else $error("read not answered");
    a_rvalid_has_cause: assert property (o_sfr_rvalid |-> $past(i_sfr.rd, 2))
        else $error("stray read valid");
    a_unmapped_reads_zero: assert property ($past(rd_none, 2) |-> o_sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_unused_bit_zero: assert property ($past(rd_cfg, 2) |-> !o_sfr_rdata[4])
        else $error("bit 4 read as one");
    a_flag_sw_clear: assert property ($fell(o_cycle_ovf_flag) |-> $past(wr_clr))
        else $error("flag cleared without write");
    a_int_needs_flag: assert property (o_pca_int |-> $past(o_cycle_ovf_flag))
        else $error("interrupt without flag");
    a_cycle_event_flag: assert property ((($past(i_cnt) & len_mask) == len_mask
        && i_cnt != $past(i_cnt) && $stable(o_cycle_len_sel)) |-> ##[0:2] o_cycle_ovf_flag)
        else $error("cycle wrap missed");
    a_len_follows_sel: assert property ((i_chan_mode[1] != PPCC_MODE_WIDE
        && $stable(i_chan_mode[1]) && $stable(o_cycle_len_sel)) [*3]
        |-> o_chan_len[1] == 5'h08 + {2'b00, o_cycle_len_sel})
        else $error("cycle length wrong");
    a_wide_len_fixed: assert property ((i_chan_mode[2] == PPCC_MODE_WIDE) [*2]
        |-> o_chan_len[2] == `PPCC_WIDE_LEN)
        else $error("wide length wrong");
    c_flag_rises: cover property ($rose(o_cycle_ovf_flag));
    c_int_rises: cover property ($rose(o_pca_int));
    c_wrap_seen: cover property (i_cnt_ovf);
endmodule
bind ppcc_top ppcc_top_sva ppcc_top_sva_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_sfr(i_sfr), .i_cnt(i_cnt), .i_cnt_ovf(i_cnt_ovf), .i_chan_mode(i_chan_mode),
    .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid), .o_cmp(o_cmp),
    .o_chan_len(o_chan_len), .o_cycle_len_sel(o_cycle_len_sel),
    .o_cycle_ovf_flag(o_cycle_ovf_flag), .o_pca_int(o_pca_int));

// *** testbench/ppcc_top_tb.sv ***
`timescale 1ns/1ps
`include "ppcc_defs.svh"
module ppcc_top_tb;
    import ppcc_pkg::*;
    logic                            i_ref_clk = 1'b0;
    logic                            i_rst_n = 1'b0;
    ppcc_sfr_req_t                   i_sfr = '0;
    logic [15:0]                     i_cnt = 16'h0000;
    logic                            i_cnt_ovf = 1'b0;
    ppcc_mode_t [`PPCC_NCH-1:0]      i_chan_mode;
    logic [7:0]                      o_sfr_rdata;
    logic                            o_sfr_rvalid;
    logic [`PPCC_NCH-1:0][15:0]      o_cmp;
    logic [`PPCC_NCH-1:0][4:0]       o_chan_len;
    logic [2:0]                      o_cycle_len_sel;
    logic                            o_cycle_ovf_flag;
    logic                            o_pca_int;
    int                              fail_count = 0;
    int                              compares = 0;
    // 200 MHz clock
    always #2.5 i_ref_clk = ~i_ref_clk;
    ppcc_top ppcc_top_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_sfr(i_sfr),
        .i_cnt(i_cnt), .i_cnt_ovf(i_cnt_ovf), .i_chan_mode(i_chan_mode),
        .o_sfr_rdata(o_sfr_rdata), .o_sfr_rvalid(o_sfr_rvalid), .o_cmp(o_cmp),
        .o_chan_len(o_chan_len), .o_cycle_len_sel(o_cycle_len_sel),
        .o_cycle_ovf_flag(o_cycle_ovf_flag), .o_pca_int(o_pca_int));
    // --------------------
    // helpers
    // --------------------
    function automatic logic [15:0] mask_of(input logic [2:0] s);
        return 16'hFFFF >> (4'h8 - {1'b0, s});
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk) i_sfr <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_ref_clk) i_sfr <= '0;
        // return off the edge so callers see the settled effect of the write
        @(negedge i_ref_clk);
    endtask
    // bounded wait for the read answer; a missing answer counts as a mismatch
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        int n;
        n = 0;
        @(posedge i_ref_clk) i_sfr <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge i_ref_clk) i_sfr <= '0;
        // look between edges so the registered answer has settled
        @(negedge i_ref_clk);
        while (o_sfr_rvalid !== 1'b1 && n < 4) begin
            @(negedge i_ref_clk);
            n++;
        end
        chk(16'(o_sfr_rvalid), 16'h0001);
        chk(16'(o_sfr_rdata), 16'(e));
    endtask
    task automatic pulse_wrap;
        @(posedge i_ref_clk) i_cnt_ovf <= 1'b1;
        @(posedge i_ref_clk) i_cnt_ovf <= 1'b0;
        cyc(2);
        @(negedge i_ref_clk);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles the sequence needs
    initial begin
        cyc(20000);
        fail_count++;
        wrap_up();
    end
    // --------------------
    // sequence
    // --------------------
    initial begin
        logic [15:0] rl [3];
        logic [15:0] cv [3];
        logic [7:0]  d;
        i_chan_mode[0] = PPCC_MODE_OTHER;
        i_chan_mode[1] = PPCC_MODE_NBIT;
        i_chan_mode[2] = PPCC_MODE_WIDE;
        void'($urandom(49989));
        cyc(16);
        i_rst_n <= 1'b1;
        rchk(`PPCC_CFG_ADDR, `PPCC_CFG_RESET);
        // every length code with random upper bits; counter idle so no wrap
        for (int i = 0; i < 8; i++) begin
            d = {5'($urandom), 3'(i)};
            wr(`PPCC_CFG_ADDR, d);
            rchk(`PPCC_CFG_ADDR, d & 8'hEF);
            chk(16'(o_chan_len[1]), 16'h0008 + 16'(i));
            chk(16'(o_cycle_len_sel), 16'(i));
            chk(16'(o_chan_len[2]), 16'(`PPCC_WIDE_LEN));
            chk(16'(o_pca_int), 16'(d[6] & d[5]));
        end
        wr(8'h00, 8'($urandom));
        rchk(8'h00, 8'h00);
        // shadow words first, then live compares at the same addresses
        wr(`PPCC_CFG_ADDR, 8'h80);
        foreach (rl[k]) begin
            rl[k] = 16'($urandom);
            wr(`PPCC_CMP_BASE + 8'(2 * k), rl[k][7:0]);
            wr(`PPCC_CMP_BASE + 8'(2 * k + 1), rl[k][15:8]);
        end
        wr(`PPCC_CFG_ADDR, 8'h00);
        foreach (cv[k]) begin
            cv[k] = 16'($urandom);
            wr(`PPCC_CMP_BASE + 8'(2 * k), cv[k][7:0]);
            wr(`PPCC_CMP_BASE + 8'(2 * k + 1), cv[k][15:8]);
            chk(o_cmp[k], cv[k]);
        end
        rchk(`PPCC_CMP_BASE, cv[0][7:0]);
        wr(`PPCC_CFG_ADDR, 8'h80);
        rchk(`PPCC_CMP_BASE + 8'h01, rl[0][15:8]);
        // one short of the selected bit must not flag; the exact bit must
        for (int s = 0; s < 8; s++) begin
            wr(`PPCC_CFG_ADDR, 8'h40 | 8'(s));
            @(posedge i_ref_clk) i_cnt <= mask_of(3'(s)) >> 1;
            @(posedge i_ref_clk) i_cnt <= (mask_of(3'(s)) >> 1) + 16'h0001;
            cyc(4);
            chk(16'(o_cycle_ovf_flag), 16'h0000);
            @(posedge i_ref_clk) i_cnt <= mask_of(3'(s));
            @(posedge i_ref_clk) i_cnt <= mask_of(3'(s)) + 16'h0001;
            cyc(4);
            chk(16'(o_cycle_ovf_flag), 16'h0001);
            chk(16'(o_pca_int), 16'h0001);
            chk(o_cmp[1], (s == 0) ? cv[1] : rl[1]);
            chk(o_cmp[0], cv[0]);
            wr(`PPCC_CFG_ADDR, 8'h40 | 8'(s));
            cyc(1);
            chk(16'(o_cycle_ovf_flag), 16'h0000);
        end
        wr(`PPCC_CFG_ADDR, 8'h00);
        pulse_wrap();
        chk(o_cmp[2], cv[2]);
        wr(`PPCC_CFG_ADDR, 8'h08);
        pulse_wrap();
        chk(o_cmp[2], rl[2]);
        chk(o_cmp[0], cv[0]);
        wrap_up();
    end
endmodule
